/* File: core/ftbsp_consts.svh */
// Constants for the flow-through burst SRAM port
`ifndef FTBSP_CONSTS_SVH
`define FTBSP_CONSTS_SVH

// Array organisation
`define FTBSP_ADDR_W 17
`define FTBSP_LANES 4
`define FTBSP_LANE_DATA_W 8
`define FTBSP_LANE_W 9
`define FTBSP_BURST_W 2
`define FTBSP_BURST_LEN 4

// Lane masks
`define FTBSP_LANE_ALL 4'hf
`define FTBSP_LANE_NONE 4'h0

// Write buffer depth
`define FTBSP_BUF_DEPTH 2

// Test port instruction register
`define FTBSP_IR_W 4
`define FTBSP_IR_CAPTURE 4'h1
`define FTBSP_TAP_RESET_VAL 4'h0

`endif

/* File: core/ftbsp_pkg.sv */
// Types shared by the flow-through burst SRAM port
package ftbsp_pkg;

	// Burst order selected by the static order pin
	typedef enum logic
	{
		BURST_LINEAR      = 1'b0,
		BURST_INTERLEAVED = 1'b1
	} ftbsp_order_t;

	// Test controller states, Gray steps along the usual path
	typedef enum logic [3:0]
	{
		TAP_RESET    = 4'h0,
		TAP_IDLE     = 4'h1,
		TAP_SEL_DR   = 4'h3,
		TAP_CAP_DR   = 4'h2,
		TAP_SHIFT_DR = 4'h6,
		TAP_EXIT1_DR = 4'h7,
		TAP_PAUSE_DR = 4'h5,
		TAP_EXIT2_DR = 4'h4,
		TAP_UPD_DR   = 4'hc,
		TAP_SEL_IR   = 4'hd,
		TAP_CAP_IR   = 4'hf,
		TAP_SHIFT_IR = 4'he,
		TAP_EXIT1_IR = 4'ha,
		TAP_PAUSE_IR = 4'hb,
		TAP_EXIT2_IR = 4'h9,
		TAP_UPD_IR   = 4'h8
	} ftbsp_tap_state_t;

endpackage

/* File: core/ftbsp_buf.sv */
// Small valid/ready buffer between the write input register and the array
module ftbsp_buf
#(
	parameter int WIDTH = 36,
	parameter int DEPTH = 2
)
(
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	// Pointers wrap naturally, so the depth must be a power of two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		$error("ftbsp_buf: DEPTH must be a power of two, 2 or more");

	logic [WIDTH-1:0] store_r [DEPTH];
	logic [PW-1:0]    wrPtr_r;
	logic [PW-1:0]    rdPtr_r;
	logic [CW-1:0]    count_r;
	logic             push;
	logic             pop;

	// Honest full and empty flags
	assign inReady  = (count_r != CW'(DEPTH));
	assign outValid = (count_r != '0);
	assign outData  = store_r[rdPtr_r];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// Entry storage
	always_ff @(posedge sys_clk)
	begin
		if (push)
			store_r[wrPtr_r] <= inData;
	end

	// Pointers and fill level
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (push)
				wrPtr_r <= wrPtr_r + PW'(1);
			if (pop)
				rdPtr_r <= rdPtr_r + PW'(1);
			if (push && !pop)
				count_r <= count_r + CW'(1);
			else if (pop && !push)
				count_r <= count_r - CW'(1);
		end
	end

endmodule

/* File: core/ftbsp_tap.sv */
// Test access port controller with bypass path, oversampled test clock
`include "ftbsp_consts.svh"

module ftbsp_tap
	import ftbsp_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic testClk,
	input  wire logic testModeSel,
	input  wire logic testDataIn,
	output logic      testDataOut,
	output logic      testDataOutOe
);

	localparam int IRW = `FTBSP_IR_W;

	ftbsp_tap_state_t state_r;
	ftbsp_tap_state_t state_nxt;
	logic [2:0]       tckMeta_r;
	logic [2:0]       tckSync_r;
	logic             tckPrev_r;
	logic             tckRise;
	logic             tckFall;
	logic [IRW-1:0]   irShift_r;
	logic             bypass_r;

	// Two-flop synchronisers for the test pins
	always_ff @(posedge sys_clk)
	begin
		tckMeta_r <= {testClk, testModeSel, testDataIn};
		tckSync_r <= tckMeta_r;
		tckPrev_r <= tckSync_r[2];
	end

	// Test clock edges seen in the system clock
	assign tckRise = tckSync_r[2] & ~tckPrev_r;
	assign tckFall = ~tckSync_r[2] & tckPrev_r;

	// Standard controller walk, mode select taken at rising edge
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			TAP_RESET:    state_nxt = tckSync_r[1] ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:     state_nxt = tckSync_r[1] ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR:   state_nxt = tckSync_r[1] ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR:   state_nxt = tckSync_r[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: state_nxt = tckSync_r[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: state_nxt = tckSync_r[1] ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: state_nxt = tckSync_r[1] ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: state_nxt = tckSync_r[1] ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR:   state_nxt = tckSync_r[1] ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR:   state_nxt = tckSync_r[1] ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR:   state_nxt = tckSync_r[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: state_nxt = tckSync_r[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: state_nxt = tckSync_r[1] ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: state_nxt = tckSync_r[1] ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: state_nxt = tckSync_r[1] ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR:   state_nxt = tckSync_r[1] ? TAP_SEL_DR : TAP_IDLE;
			default:      state_nxt = TAP_RESET;
		endcase
	end

	// Controller state, cleared at power-up reset
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			state_r <= TAP_RESET;
		else if (tckRise)
			state_r <= state_nxt;
	end

	// Instruction and bypass shift paths, shifted at rising edge
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			irShift_r <= `FTBSP_TAP_RESET_VAL;
			bypass_r  <= 1'b0;
		end
		else if (tckRise)
		begin
			case (state_r)
				TAP_CAP_IR:   irShift_r <= `FTBSP_IR_CAPTURE;
				TAP_SHIFT_IR: irShift_r <= {tckSync_r[0], irShift_r[IRW-1:1]};
				TAP_CAP_DR:   bypass_r  <= 1'b0;
				TAP_SHIFT_DR: bypass_r  <= tckSync_r[0];
				default:      bypass_r  <= bypass_r;
			endcase
		end
	end

	// Serial output changes at falling edge, live only while shifting
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			testDataOut   <= 1'b0;
			testDataOutOe <= 1'b0;
		end
		else if (tckFall)
		begin
			testDataOut   <= (state_r == TAP_SHIFT_IR) ? irShift_r[0]
			                                           : bypass_r;
			testDataOutOe <= (state_r == TAP_SHIFT_IR) ||
			                 (state_r == TAP_SHIFT_DR);
		end
	end

endmodule

/* File: core/ftbsp_core.sv */
// Flow-through burst SRAM port: bus decode, burst counter, array, test port
`include "ftbsp_consts.svh"

module ftbsp_core
	import ftbsp_pkg::*;
#(
	parameter int ADDR_W = `FTBSP_ADDR_W
)
(
	input  wire logic              sys_clk,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] addrIn,
	input  wire logic              cacheAddrStrobeN,
	input  wire logic              procAddrStrobeN,
	input  wire logic              burstAdvanceN,
	input  wire logic              chipEnableN,
	input  wire logic              selectHigh,
	input  wire logic              selectLowN,
	input  wire logic              allLanesWriteN,
	input  wire logic              byteWriteGateN,
	input  wire logic [3:0]        laneWriteSelN,
	input  wire logic              outEnableN,
	input  wire logic              burstOrderSel,
	input  wire logic              sleepReq,
	input  wire logic [31:0]       dataPinsIn,
	output logic      [31:0]       dataPinsOut,
	output logic                   dataPinsOe,
	input  wire logic [3:0]        parityPinsIn,
	output logic      [3:0]        parityPinsOut,
	output logic                   parityPinsOe,
	output logic                   writeReady,
	input  wire logic              testClk,
	input  wire logic              testModeSel,
	input  wire logic              testDataIn,
	output logic                   testDataOut,
	output logic                   testDataOutOe
);

	// ****************************************************************
	// Sizes and elaboration checks
	// ****************************************************************

	localparam int LANES  = `FTBSP_LANES;
	localparam int LDW    = `FTBSP_LANE_DATA_W;
	localparam int LW     = `FTBSP_LANE_W;
	localparam int BW     = `FTBSP_BURST_W;
	localparam int WORD_W = LANES * LW;
	localparam int ENT_W  = ADDR_W + LANES + WORD_W;
	localparam int WORDS  = 1 << ADDR_W;

	// The burst field needs room above it, and the array must stay sane
	if (ADDR_W <= BW || ADDR_W > 20)
		$error("ftbsp_core: ADDR_W must lie between 3 and 20");

	// Four cycles per burst must match the counter width
	if ((1 << BW) != `FTBSP_BURST_LEN)
		$error("ftbsp_core: burst counter width does not fit burst length");

	// ****************************************************************
	// Shared decoding
	// ****************************************************************

	// Low address bits for one step of a burst
	function automatic logic [BW-1:0] burst_lo
	(
		input logic [BW-1:0] start,
		input logic [BW-1:0] step,
		input ftbsp_order_t  order
	);
		logic [BW-1:0] res;
		if (order == BURST_INTERLEAVED)
			res = start ^ step;
		else
			res = BW'(start + step);
		return res;
	endfunction

	// Full address of a burst step
	function automatic logic [ADDR_W-1:0] burst_addr
	(
		input logic [ADDR_W-1:0] base,
		input logic [BW-1:0]     step,
		input ftbsp_order_t      order
	);
		return {base[ADDR_W-1:BW], burst_lo(base[BW-1:0], step, order)};
	endfunction

	// Lanes written by one cycle's write controls
	function automatic logic [LANES-1:0] lane_mask
	(
		input logic             allN,
		input logic             gateN,
		input logic [LANES-1:0] selN
	);
		logic [LANES-1:0] m;
		if (!allN)
			m = `FTBSP_LANE_ALL;
		else if (!gateN)
			m = ~selN;
		else
			m = `FTBSP_LANE_NONE;
		return m;
	endfunction

	// ****************************************************************
	// Asynchronous pins
	// ****************************************************************

	logic         sleepMeta_r;
	logic         sleepSync_r;
	logic         orderMeta_r;
	logic         orderSync_r;
	ftbsp_order_t order;
	logic         clkEn;

	// Two-flop synchronisers for sleep and burst order
	always_ff @(posedge sys_clk)
	begin
		sleepMeta_r <= sleepReq;
		sleepSync_r <= sleepMeta_r;
		orderMeta_r <= burstOrderSel;
		orderSync_r <= orderMeta_r;
	end

	// Order pin is static in use, so one synchronised copy suffices
	assign order = ftbsp_order_t'(orderSync_r);

	// Sleep blocks every bus-side update; the array keeps its contents
	assign clkEn = ~sleepSync_r;

	// ****************************************************************
	// Address strobes, selection and burst counter
	// ****************************************************************

	logic              chipSel;
	logic              procLoad;
	logic              addrLoad;
	logic              advance;
	logic              selNow;
	logic [ADDR_W-1:0] base_r;
	logic [BW-1:0]     step_r;
	logic              burstLive_r;
	logic              selected_r;
	logic [ADDR_W-1:0] curAddr;
	logic [ADDR_W-1:0] cycleAddr;

	// Three-input select at the clock edge
	assign chipSel = ~chipEnableN & selectHigh & ~selectLowN;

	// Processor strobe is gated by chip enable
	assign procLoad = ~procAddrStrobeN & ~chipEnableN;

	// Either strobe path loads a new address
	assign addrLoad = ~cacheAddrStrobeN | procLoad;

	// Advance only within a burst already started
	assign advance = ~addrLoad & ~burstAdvanceN & burstLive_r;

	// Selection that holds for the cycle now beginning
	assign selNow = addrLoad ? chipSel : selected_r;

	// Address being presented to the array this cycle
	assign curAddr = burst_addr(base_r, step_r, order);

	// Address that the coming edge makes current
	always_comb
	begin
		if (addrLoad)
			cycleAddr = addrIn;
		else if (advance)
			cycleAddr = burst_addr(base_r, BW'(step_r + BW'(1)), order);
		else
			cycleAddr = curAddr;
	end

	// Address register and burst step
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			base_r      <= '0;
			step_r      <= '0;
			burstLive_r <= 1'b0;
		end
		else if (clkEn)
		begin
			if (addrLoad)
			begin
				base_r      <= addrIn;
				step_r      <= '0;
				burstLive_r <= chipSel;
			end
			else if (advance)
				step_r <= BW'(step_r + BW'(1));
		end
	end

	// Selection updated by each address strobe
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			selected_r <= 1'b0;
		else if (clkEn && addrLoad)
			selected_r <= chipSel;
	end

	// ****************************************************************
	// Write input register
	// ****************************************************************

	logic [LANES-1:0]  laneMask;
	logic              writeGo;
	logic              writeActive_r;
	logic              pend_r;
	logic [ADDR_W-1:0] pendAddr_r;
	logic [LANES-1:0]  pendMask_r;
	logic [WORD_W-1:0] pendData_r;
	logic [WORD_W-1:0] pinWord;
	logic              bufInReady;

	// Lanes requested by this edge's write controls
	assign laneMask = lane_mask(allLanesWriteN, byteWriteGateN,
	                            laneWriteSelN);

	// Deselected or stalled cycles take no write
	assign writeGo = (laneMask != `FTBSP_LANE_NONE) & selNow & clkEn &
	                 writeReady;

	// Input register may take a word when empty or draining now
	assign writeReady = ~pend_r | bufInReady;

	// Pins packed into lanes of eight data bits and one parity bit
	always_comb
	begin
		pinWord = '0;
		for (int i = 0; i < LANES; i++)
			pinWord[i*LW +: LW] = {parityPinsIn[i],
			                       dataPinsIn[i*LDW +: LDW]};
	end

	// Write word, lanes and address captured at the edge
	always_ff @(posedge sys_clk)
	begin
		if (writeGo)
		begin
			pendData_r <= pinWord;
			pendMask_r <= laneMask;
			pendAddr_r <= cycleAddr;
		end
	end

	// Input register fill flag
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			pend_r <= 1'b0;
		else if (writeGo)
			pend_r <= 1'b1;
		else if (bufInReady)
			pend_r <= 1'b0;
	end

	// Marks a write cycle so the drivers stay off
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			writeActive_r <= 1'b0;
		else if (clkEn)
			writeActive_r <= writeGo;
	end

	// ****************************************************************
	// Write buffer and array
	// ****************************************************************

	logic              bufOutValid;
	logic [ENT_W-1:0]  bufOutData;
	logic [ADDR_W-1:0] wrAddr;
	logic [LANES-1:0]  wrMask;
	logic [WORD_W-1:0] wrData;
	logic              arrayWrite;
	logic [WORD_W-1:0] mem [WORDS];
	logic [WORD_W-1:0] rdWord;

	// Two entries absorb a stall of the array during sleep
	ftbsp_buf
	#(
		.WIDTH (ENT_W),
		.DEPTH (`FTBSP_BUF_DEPTH)
	)
	u_buf
	(
		.sys_clk  (sys_clk),
		.reset    (reset),
		.inValid  (pend_r),
		.inReady  (bufInReady),
		.inData   ({pendAddr_r, pendMask_r, pendData_r}),
		.outValid (bufOutValid),
		.outReady (clkEn),
		.outData  (bufOutData)
	);

	// Buffer entry fields
	assign wrAddr     = bufOutData[ENT_W-1 -: ADDR_W];
	assign wrMask     = bufOutData[WORD_W +: LANES];
	assign wrData     = bufOutData[WORD_W-1:0];
	assign arrayWrite = bufOutValid & clkEn;

	// Array update per nine-bit lane; never cleared, so sleep keeps data
	always_ff @(posedge sys_clk)
	begin
		if (arrayWrite)
		begin
			for (int i = 0; i < LANES; i++)
				if (wrMask[i])
					mem[wrAddr][i*LW +: LW] <= wrData[i*LW +: LW];
		end
	end

	// ****************************************************************
	// Flow-through read and output drivers
	// ****************************************************************

	// Array read straight from the current address, no output register
	assign rdWord = mem[curAddr];

	// Lanes unpacked back to data and parity pins
	always_comb
	begin
		dataPinsOut   = '0;
		parityPinsOut = '0;
		for (int i = 0; i < LANES; i++)
		begin
			dataPinsOut[i*LDW +: LDW] = rdWord[i*LW +: LDW];
			parityPinsOut[i]          = rdWord[i*LW + LDW];
		end
	end

	// Drivers follow output enable without a clock edge
	assign dataPinsOe = ~outEnableN & selected_r & ~writeActive_r &
	                    clkEn;
	assign parityPinsOe = dataPinsOe;

	// ****************************************************************
	// Test access port
	// ****************************************************************

	// Controller runs from power-up reset and the sampled test clock
	ftbsp_tap u_tap
	(
		.sys_clk       (sys_clk),
		.reset         (reset),
		.testClk       (testClk),
		.testModeSel   (testModeSel),
		.testDataIn    (testDataIn),
		.testDataOut   (testDataOut),
		.testDataOutOe (testDataOutOe)
	);

endmodule

/* File: test/ftbsp_host.sv */
// Bus-side partner model: order pin and shared data pin levels
module ftbsp_host
(
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        orderReq,
	output logic             burstOrderSel,
	input  wire logic        hostDrive,
	input  wire logic [35:0] hostData,
	input  wire logic        dataOe,
	input  wire logic        parityOe,
	input  wire logic [35:0] devData,
	output logic      [35:0] pinsSeen
);
	timeunit 1ns;
	timeprecision 100ps;
	// ************
	// Pin levels
	// ************
	logic [35:0] floatR = 36'h5a5a5a5a5;
	// Order pin only follows the request while reset holds the device
	always_ff @(posedge sys_clk)
		if (reset)
			burstOrderSel <= orderReq;
	// Released pins toggle every cycle, so stale data never matches
	always_ff @(posedge sys_clk)
		floatR <= ~floatR;
	// Host data wins while it drives; else device lanes or the float
	always_comb
	begin
		pinsSeen = floatR;
		if (dataOe)
			pinsSeen[31:0] = devData[31:0];
		if (parityOe)
			pinsSeen[35:32] = devData[35:32];
		if (hostDrive)
			pinsSeen = hostData;
	end
endmodule

/* File: test/ftbsp_assertions.sv */
// Concurrent checks at the ports of the burst SRAM port
module ftbsp_checker
(
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire logic       cacheAddrStrobeN,
	input wire logic       chipEnableN,
	input wire logic       selectHigh,
	input wire logic       selectLowN,
	input wire logic       allLanesWriteN,
	input wire logic       byteWriteGateN,
	input wire logic [3:0] laneWriteSelN,
	input wire logic       outEnableN,
	input wire logic       sleepReq,
	input wire logic       dataPinsOe,
	input wire logic       parityPinsOe,
	input wire logic       writeReady,
	input wire logic       testClk,
	input wire logic       testDataOut,
	input wire logic       testDataOutOe
);
	// ************
	// Properties
	// ************
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	logic anyOe;
	// Either lane group driving
	assign anyOe = dataPinsOe | parityPinsOe;
	sequence selLoad;
		!cacheAddrStrobeN && !chipEnableN && selectHigh && !selectLowN;
	endsequence
	sequence noWrite;
		allLanesWriteN && (byteWriteGateN || &laneWriteSelN);
	endsequence
	sequence awake;
		!sleepReq [*3];
	endsequence
	oe_high_z_a: assert property (outEnableN |-> !anyOe)
		else $error("drivers enabled with output enable high");
	all_write_off_a: assert property
		(selLoad ##0 (!allLanesWriteN && writeReady) |=> !anyOe)
		else $error("drivers enabled after global write");
	lane_write_off_a: assert property
		(selLoad ##0 (!byteWriteGateN && !(&laneWriteSelN) && writeReady)
		|=> !anyOe)
		else $error("drivers enabled after lane write");
	deselect_z_a: assert property
		((!cacheAddrStrobeN && (chipEnableN || !selectHigh || selectLowN))
		|=> !anyOe)
		else $error("drivers enabled while deselected");
	read_drive_a: assert property
		(awake ##0 selLoad ##0 noWrite ##1 !outEnableN
		|-> dataPinsOe && parityPinsOe)
		else $error("read lanes not driven");
	sleep_z_a: assert property (sleepReq [*4] |-> !anyOe)
		else $error("drivers enabled in sleep");
	tap_reset_a: assert property
		($fell(reset) |-> !testDataOutOe && !testDataOut)
		else $error("test output active after reset");
	tdo_fall_a: assert property
		(($changed(testDataOut) || $changed(testDataOutOe)) |-> !testClk)
		else $error("test output moved while test clock high");
endmodule

bind ftbsp_core ftbsp_checker i_ftbsp_checker
(
	.sys_clk, .reset, .cacheAddrStrobeN, .chipEnableN, .selectHigh,
	.selectLowN, .allLanesWriteN, .byteWriteGateN, .laneWriteSelN,
	.outEnableN, .sleepReq, .dataPinsOe, .parityPinsOe, .writeReady,
	.testClk, .testDataOut, .testDataOutOe
);

/* File: test/ftbsp_core_bench.sv */
// Self-checking bench for the flow-through burst SRAM port
module ftbsp_core_bench;
	timeunit 1ns;
	timeprecision 100ps;
	// ************
	// Signals and instances
	// ************
	localparam logic [5:0] IDLE = 6'h3e, RD = 6'h1e, BURST_ADVANCE_N = 6'h36;
	localparam logic [5:0] WR = 6'h19, LW = 6'h1d, PS = 6'h2e;
	logic        sys_clk = 1'b0, reset = 1'b1, tck = 1'b0, tms = 1'b1;
	logic        ceN = 1'b0, selHi = 1'b1, selLoN = 1'b0, oeN = 1'b0;
	logic        order = 1'b0, sleep = 1'b0, tdi = 1'b0, orderPin;
	logic [5:0]  ctl = IDLE;
	logic [3:0]  addr = 4'h0, lanes = 4'hf, pOut;
	logic [35:0] wdata = 36'h0, pins, seen;
	logic [35:0] exp [16];
	logic [31:0] dOut;
	logic        dOe, pOe, wRdy, tdo, tdoOe;
	int          failCount = 0, samplesChecked = 0, cycles = 0;
	assign seen = {pOut, dOut};
	ftbsp_core #(.ADDR_W(4)) i_ftbsp_core
	(
		.sys_clk, .reset, .addrIn(addr), .cacheAddrStrobeN(ctl[5]),
		.procAddrStrobeN(ctl[4]), .burstAdvanceN(ctl[3]),
		.chipEnableN(ceN), .selectHigh(selHi), .selectLowN(selLoN),
		.allLanesWriteN(ctl[2]), .byteWriteGateN(ctl[1]),
		.laneWriteSelN(lanes), .outEnableN(oeN), .burstOrderSel(orderPin),
		.sleepReq(sleep), .dataPinsIn(pins[31:0]), .dataPinsOut(dOut),
		.dataPinsOe(dOe), .parityPinsIn(pins[35:32]), .parityPinsOut(pOut),
		.parityPinsOe(pOe), .writeReady(wRdy), .testClk(tck),
		.testModeSel(tms), .testDataIn(tdi), .testDataOut(tdo),
		.testDataOutOe(tdoOe)
	);
	ftbsp_host i_ftbsp_host
	(
		.sys_clk, .reset, .orderReq(order), .burstOrderSel(orderPin),
		.hostDrive(ctl[0]), .hostData(wdata), .dataOe(dOe),
		.parityOe(pOe), .devData(seen), .pinsSeen(pins)
	);
	// Clock
	initial
		forever #12.5 sys_clk = ~sys_clk;
	// ************
	// Tasks
	// ************
	task automatic stopTest();
		$display("checks %0d mismatches %0d", samplesChecked, failCount);
		if (failCount == 0 && samplesChecked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input string what, input logic [35:0] e, g);
		samplesChecked++;
		if (g !== e)
		begin
			failCount++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	// Compare of one driver or ready flag
	task automatic checkFlag(input string what, input logic e, g);
		samplesChecked++;
		if (g !== e)
		begin
			failCount++;
			$display("mismatch %s expected %b seen %b", what, e, g);
		end
	endtask
	task automatic step(input logic [3:0] a, input logic [5:0] c);
		addr = a;
		ctl = c;
		@(posedge sys_clk);
		#2;
	endtask
	task automatic idle(input int n);
		ctl = IDLE;
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task automatic wr(input logic [3:0] a, input logic [5:0] c,
		input logic [35:0] d);
		wdata = d;
		step(a, c);
	endtask
	task automatic rd(input logic [3:0] a);
		step(a, RD);
		check("read data", exp[a], seen);
		checkFlag("read drive", 1'b1, dOe & pOe);
	endtask
	task automatic doReset(input logic o);
		reset = 1'b1;
		order = o;
		repeat (16) @(posedge sys_clk);
		#2;
		reset = 1'b0;
	endtask
	task automatic testWrite();
		for (int a = 0; a < 16; a++)
		begin
			exp[a] = 36'h9a5c3e1f0 ^ {9{4'(a)}};
			lanes = 4'(a);
			wr(4'(a), WR, exp[a]);
		end
		lanes = 4'hf;
		idle(3);
		for (int a = 0; a < 16; a++)
			rd(4'(a));
	endtask
	task automatic testBurst(input logic o);
		logic [3:0] a;
		doReset(o);
		step(4'h5, RD);
		for (int k = 0; k < 4; k++)
		begin
			a = o ? 4'h5 ^ 4'(k) : {2'b01, 2'(1 + k)};
			check("burst data", exp[a], seen);
			if (k == 1)
			begin
				step(4'h0, IDLE);
				check("burst hold", exp[a], seen);
			end
			step(4'h0, BURST_ADVANCE_N);
		end
	endtask
	task automatic testLanes();
		lanes = 4'h0;
		wr(4'h2, 6'h1f, 36'h0);
		lanes = 4'ha;
		wr(4'h3, LW, 36'hfffffffff);
		exp[3] = exp[3] | 36'h500ff00ff;
		checkFlag("lane write drive", 1'b0, dOe | pOe);
		lanes = 4'hf;
		idle(3);
		rd(4'h2);
		rd(4'h3);
	endtask
	task automatic testSelect();
		for (int i = 0; i < 3; i++)
		begin
			{ceN, selHi, selLoN} = i == 0 ? 3'b110 : i == 1 ? 3'b000 : 3'b011;
			wr(4'h0, WR, 36'h0);
			step(4'h0, RD);
			checkFlag("deselect drive", 1'b0, dOe | pOe);
		end
		{ceN, selHi, selLoN} = 3'b010;
		idle(3);
		rd(4'h0);
		rd(4'h2);
		ceN = 1'b1;
		step(4'h1, PS);
		check("gated strobe", exp[2], seen);
		ceN = 1'b0;
		step(4'h1, PS);
		check("processor strobe", exp[1], seen);
		oeN = 1'b1;
		#1;
		checkFlag("enable off", 1'b0, dOe | pOe);
		@(posedge sys_clk);
		#2;
		oeN = 1'b0;
	endtask
	task automatic testSleep();
		rd(4'h1);
		sleep = 1'b1;
		idle(4);
		checkFlag("sleep drive", 1'b0, dOe | pOe);
		wr(4'h0, WR, 36'h0);
		checkFlag("write ready", 1'b1, wRdy);
		idle(2);
		sleep = 1'b0;
		idle(4);
		rd(4'h0);
		rd(4'h3);
	endtask
	task automatic tapClk(input logic m, input logic d);
		tms = m;
		tdi = d;
		repeat (8) @(posedge sys_clk);
		#2;
		tck = 1'b1;
		repeat (8) @(posedge sys_clk);
		#2;
		tck = 1'b0;
		repeat (8) @(posedge sys_clk);
		#2;
	endtask
	task automatic testTap();
		repeat (5) tapClk(1'b1, 1'b0);
		tapClk(1'b0, 1'b0);
		checkFlag("test out idle", 1'b0, tdoOe);
		tapClk(1'b1, 1'b0);
		tapClk(1'b0, 1'b0);
		tapClk(1'b0, 1'b0);
		check("test out shift", 36'h2, 36'({tdoOe, tdo}));
		tapClk(1'b0, 1'b1);
		check("test out bypass", 36'h3, 36'({tdoOe, tdo}));
		tapClk(1'b1, 1'b0);
		checkFlag("test out exit", 1'b0, tdoOe);
		repeat (3) tapClk(1'b1, 1'b0);
		tapClk(1'b0, 1'b0);
		tapClk(1'b0, 1'b0);
		check("test out ir", 36'h3, 36'({tdoOe, tdo}));
	endtask
	// ************
	// Sequence and watchdog
	// ************
	// Cut a hang short well beyond the expected run length
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failCount++;
			stopTest();
		end
	end
	// Main sequence
	initial
	begin
		doReset(1'b0);
		testWrite();
		testBurst(1'b0);
		testBurst(1'b1);
		testLanes();
		testSelect();
		testSleep();
		testTap();
		stopTest();
	end
endmodule
